/* File: logic/qdec_core.sv */
// quadrature decoder core: APB register file, sample timer, motion total and events
// assumes an APB master on i_clk_sys and encoder phases already synchronous to it
`timescale 1ns/1ps
`include "qdec_params.svh"

// Notes on behaviour
// - writing enable one claims decoder and LED pins and starts operation
// - enable zero releases the decoder pins for general purpose use
// - LED lit by low level when polarity zero, high level when one
// - one sample per interval, 128 us doubled per code up to 131072 us
// - each sample is two's complement, sign gives rotation direction
// - both phases changing within one sample reports the value two
// - report codes 0-7 give 10..280 samples, code 8 gives one sample
// - report time equals sample interval times samples per report
// - every valid sample except double and overflowing ones is added into the 32-bit motion total
// - double transition samples leave the motion total unchanged
// - a sample that would overflow the total is dropped, overflow event raised
// - either read-and-clear task clears the motion total
// - either read-and-clear task first copies the total into the snapshot
// - report-ready fires after the selected samples when total is non-zero
// - double-ready fires after the selected samples when double count non-zero
module qdec_core
  import qdec_pkg::*;
#(
  parameter int P_SAMPLE_BASE_US = `QD_SAMPLE_BASE_US
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output word_t o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_phase_a,
  input wire logic i_phase_b,
  output logic o_led,
  output logic o_led_oe,
  output logic o_pins_active,
  output logic o_irq
);

  // control registers
  logic decoder_enable, next_decoder_enable;
  logic light_polarity, next_light_polarity;
  logic [3:0] sample_interval, next_sample_interval;
  logic [3:0] report_interval, next_report_interval;
  logic [3:0] irq_mask, next_irq_mask;
  run_state_e run_state, next_run_state;
  // timing
  logic [6:0] tick_cnt, next_tick_cnt;
  logic [17:0] us_cnt, next_us_cnt;
  logic [8:0] rpt_cnt, next_rpt_cnt;
  // motion data
  word_t last_motion_value, next_last_motion_value;
  word_t motion_total, next_motion_total;
  word_t motion_total_snapshot, next_motion_total_snapshot;
  logic [3:0] double_count, next_double_count;
  logic [3:0] irq_status, next_irq_status;
  // bus and pins
  word_t next_prdata;
  logic next_pready, next_pslverr;
  logic next_led, next_led_oe, next_pins_active, next_irq;

  // decoded strobes
  logic access, wr_done, addr_hit;
  logic start_task, stop_task, clear_any, restart;
  logic tick_end, us_end, sample_pulse;
  logic step_valid, is_double, add_ovf, report_fire;
  step_t step;
  word_t step_word, rd_word;
  logic [32:0] sum;
  logic [17:0] interval_us;
  logic [8:0] report_target;
  logic [3:0] events;

  ////////////////////////////////////////////////////////////////////////////
  // apb: two-cycle access, write and read data taken on the pready edge
  assign access = i_psel && i_penable;
  assign wr_done = access && o_pready && i_pwrite;

  always_comb begin
    addr_hit = 1'b1;
    rd_word = `QD_RST_WORD;
    case (i_paddr)
      `QD_OFS_TASKS: rd_word = `QD_RST_WORD; // triggers read as zero
      `QD_OFS_IRQ_STATUS: rd_word = {28'h0, irq_status};
      `QD_OFS_IRQ_MASK: rd_word = {28'h0, irq_mask};
      `QD_OFS_ENABLE: rd_word = {31'h0, decoder_enable};
      `QD_OFS_LIGHT_POL: rd_word = {31'h0, light_polarity};
      `QD_OFS_SAMPLE_INT: rd_word = {28'h0, sample_interval};
      `QD_OFS_LAST_VALUE: rd_word = last_motion_value;
      `QD_OFS_REPORT_INT: rd_word = {28'h0, report_interval};
      `QD_OFS_TOTAL: rd_word = motion_total;
      `QD_OFS_SNAPSHOT: rd_word = motion_total_snapshot;
      default: addr_hit = 1'b0;
    endcase
  end

  // answer is computed in the first access cycle and held into the second
  always_comb begin
    next_pready = access && !o_pready;
    next_prdata = o_prdata;
    next_pslverr = 1'b0;
    if (access && !o_pready) begin
      next_prdata = i_pwrite ? `QD_RST_WORD : rd_word;
      next_pslverr = !addr_hit; // unmapped address answers with an error
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_prdata <= `QD_RST_WORD;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= next_pready;
      o_prdata <= next_prdata;
      o_pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tasks and control settings
  always_comb begin
    start_task = wr_done && i_paddr == `QD_OFS_TASKS && i_pwdata[`QD_TASK_START];
    stop_task = wr_done && i_paddr == `QD_OFS_TASKS && i_pwdata[`QD_TASK_STOP];
    clear_any = wr_done && i_paddr == `QD_OFS_TASKS
      && (i_pwdata[`QD_TASK_SNAP_CLR] || i_pwdata[`QD_TASK_READOUT_CLR]);
    next_decoder_enable = decoder_enable;
    next_light_polarity = light_polarity;
    next_sample_interval = sample_interval;
    next_report_interval = report_interval;
    next_irq_mask = irq_mask;
    if (wr_done) begin
      case (i_paddr)
        `QD_OFS_ENABLE: next_decoder_enable = i_pwdata[0];
        `QD_OFS_LIGHT_POL: next_light_polarity = i_pwdata[0];
        `QD_OFS_SAMPLE_INT: next_sample_interval = i_pwdata[3:0];
        `QD_OFS_REPORT_INT: next_report_interval = i_pwdata[3:0];
        `QD_OFS_IRQ_MASK: next_irq_mask = i_pwdata[3:0];
        default: next_irq_mask = irq_mask;
      endcase
    end
    // any write of one to enable (re)starts operation, as does start while enabled
    restart = (wr_done && i_paddr == `QD_OFS_ENABLE && i_pwdata[0])
      || (start_task && decoder_enable);
    case (run_state)
      RUN_IDLE: next_run_state = restart ? RUN_ACTIVE : RUN_IDLE;
      RUN_ACTIVE: next_run_state = (stop_task || !next_decoder_enable) ? RUN_IDLE : RUN_ACTIVE;
      default: next_run_state = RUN_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      decoder_enable <= 1'b0;
      light_polarity <= 1'b0;
      sample_interval <= `QD_RST_CODE;
      report_interval <= `QD_RST_CODE;
      irq_mask <= `QD_RST_EVENTS;
      run_state <= RUN_IDLE;
    end else begin
      decoder_enable <= next_decoder_enable;
      light_polarity <= next_light_polarity;
      sample_interval <= next_sample_interval;
      report_interval <= next_report_interval;
      irq_mask <= next_irq_mask;
      run_state <= next_run_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample timer; codes above the largest behave as the largest
  always_comb begin
    interval_us = 18'(P_SAMPLE_BASE_US) << ((sample_interval > `QD_SAMPLE_CODE_MAX) ?
      `QD_SAMPLE_CODE_MAX : sample_interval);
    case (report_interval)
      4'h0: report_target = 9'd10;
      4'h1: report_target = 9'd40;
      4'h2: report_target = 9'd80;
      4'h3: report_target = 9'd120;
      4'h4: report_target = 9'd160;
      4'h5: report_target = 9'd200;
      4'h6: report_target = 9'd240;
      4'h7: report_target = 9'd280;
      `QD_REPORT_CODE_ONE: report_target = 9'd1;
      default: report_target = 9'd1;
    endcase
  end

  assign tick_end = tick_cnt == 7'(`QD_TICK_CYCLES - 1);
  assign us_end = us_cnt >= interval_us - 18'h1; // a shortened interval ends at once, no wrap
  assign sample_pulse = run_state == RUN_ACTIVE && !restart && tick_end && us_end;

  // the count of samples per report only advances on samples, so the report
  // time is the sample interval times the selected count
  always_comb begin
    next_tick_cnt = 7'h0;
    next_us_cnt = 18'h0;
    next_rpt_cnt = rpt_cnt;
    if (restart || run_state != RUN_ACTIVE) begin
      next_rpt_cnt = 9'h0;
    end else begin
      next_tick_cnt = tick_end ? 7'h0 : tick_cnt + 7'h1;
      next_us_cnt = !tick_end ? us_cnt : (us_end ? 18'h0 : us_cnt + 18'h1);
      if (report_fire) begin
        next_rpt_cnt = 9'h0;
      end else if (step_valid) begin
        next_rpt_cnt = rpt_cnt + 9'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt <= 7'h0;
      us_cnt <= 18'h0;
      rpt_cnt <= 9'h0;
    end else begin
      tick_cnt <= next_tick_cnt;
      us_cnt <= next_us_cnt;
      rpt_cnt <= next_rpt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase decoder; ignores the pins while the decoder is released
  qdec_step_decode u_step (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_restart(restart),
    .i_sample(sample_pulse),
    .i_phase_a(i_phase_a),
    .i_phase_b(i_phase_b),
    .o_step(step),
    .o_valid(step_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // motion total; a sample landing with a clear is kept, not lost
  assign is_double = step == `QD_STEP_DOUBLE;
  assign step_word = is_double ? 32'h00000002 : {{30{step[1]}}, step};
  assign sum = {motion_total[31], motion_total} + {step_word[31], step_word};
  assign add_ovf = sum[32] != sum[31];
  assign report_fire = step_valid && rpt_cnt >= report_target - 9'h1; // lowered target fires on the next sample

  always_comb begin
    next_last_motion_value = last_motion_value;
    next_motion_total = motion_total;
    next_motion_total_snapshot = motion_total_snapshot;
    next_double_count = double_count;
    events = `QD_RST_EVENTS;
    if (step_valid) begin
      next_last_motion_value = step_word;
      events[`QD_EV_SAMPLE] = 1'b1;
    end
    if (clear_any) begin
      next_motion_total_snapshot = motion_total;
      next_motion_total = (step_valid && !is_double) ? step_word : `QD_RST_WORD;
      next_double_count = (step_valid && is_double) ? 4'h1 : 4'h0;
    end else if (step_valid && is_double) begin
      // total untouched; the double count saturates and then flags overflow
      if (double_count == `QD_DOUBLE_MAX) begin
        events[`QD_EV_OVERFLOW] = 1'b1;
      end else begin
        next_double_count = double_count + 4'h1;
      end
    end else if (step_valid && add_ovf) begin
      events[`QD_EV_OVERFLOW] = 1'b1;
    end else if (step_valid) begin
      next_motion_total = sum[31:0];
    end
    if (report_fire && next_motion_total != `QD_RST_WORD) begin
      events[`QD_EV_REPORT] = 1'b1;
    end
    if (report_fire && next_double_count != 4'h0) begin
      events[`QD_EV_DOUBLE] = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      last_motion_value <= `QD_RST_WORD;
      motion_total <= `QD_RST_WORD;
      motion_total_snapshot <= `QD_RST_WORD;
      double_count <= 4'h0;
    end else begin
      last_motion_value <= next_last_motion_value;
      motion_total <= next_motion_total;
      motion_total_snapshot <= next_motion_total_snapshot;
      double_count <= next_double_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events, write one to clear; a new event wins over its clear
  always_comb begin
    next_irq_status = irq_status;
    if (wr_done && i_paddr == `QD_OFS_IRQ_STATUS) begin
      next_irq_status = irq_status & ~i_pwdata[3:0];
    end
    next_irq_status = next_irq_status | events;
    next_irq = |(next_irq_status & next_irq_mask);
    // pins held only while enabled; LED lit whenever the decoder runs
    next_pins_active = next_decoder_enable;
    next_led_oe = next_decoder_enable;
    next_led = 1'b0;
    if (next_decoder_enable) begin
      next_led = (next_run_state == RUN_ACTIVE) ? next_light_polarity
        : !next_light_polarity;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_status <= `QD_RST_EVENTS;
      o_irq <= 1'b0;
      o_pins_active <= 1'b0;
      o_led_oe <= 1'b0;
      o_led <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      o_irq <= next_irq;
      o_pins_active <= next_pins_active;
      o_led_oe <= next_led_oe;
      o_led <= next_led;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  sequence s_sample_lands;
    ##1 step_valid ##1 (last_motion_value == $past(step_word));
  endsequence

  pins_claimed_a: assert property (
    (wr_done && i_paddr == `QD_OFS_ENABLE && i_pwdata[0])
      |=> (o_pins_active && o_led_oe && run_state == RUN_ACTIVE))
    else $error("enable write did not claim the pins");

  pins_released_a: assert property (
    !decoder_enable |-> (!o_led_oe && !o_pins_active))
    else $error("pins driven while decoder disabled");

  led_level_a: assert property (
    (decoder_enable && run_state == RUN_ACTIVE) ##1 (run_state == RUN_ACTIVE)
      |-> (o_led == light_polarity))
    else $error("LED level does not follow polarity");

  sample_refresh_a: assert property (
    sample_pulse |-> s_sample_lands)
    else $error("sample register not refreshed");

  timer_restart_a: assert property (
    restart |=> (tick_cnt == 7'h0 && us_cnt == 18'h0 && !sample_pulse))
    else $error("interval timer did not restart");

  report_count_a: assert property (
    (step_valid && report_interval == `QD_REPORT_CODE_ONE) |-> report_fire)
    else $error("single-sample report did not fire");

  total_add_a: assert property (
    (step_valid && !is_double && !add_ovf && !clear_any)
      |=> (motion_total == $past(sum[31:0])))
    else $error("valid sample not added to total");

  double_kept_a: assert property (
    (step_valid && is_double && !clear_any) |=> $stable(motion_total))
    else $error("double transition changed the total");

  overflow_drop_a: assert property (
    (step_valid && !is_double && add_ovf && !clear_any)
      |=> ($stable(motion_total) && irq_status[`QD_EV_OVERFLOW]))
    else $error("overflowing sample not dropped or flagged");

  clear_total_a: assert property (
    (clear_any && !step_valid) |=> (motion_total == `QD_RST_WORD))
    else $error("clear task left total non-zero");

  snapshot_copy_a: assert property (
    clear_any |=> (motion_total_snapshot == $past(motion_total)))
    else $error("snapshot does not hold the old total");

  report_ready_a: assert property (
    (report_fire && next_motion_total != `QD_RST_WORD) |=> irq_status[`QD_EV_REPORT])
    else $error("report-ready event missing");

  double_ready_a: assert property (
    (report_fire && next_double_count != 4'h0) |=> irq_status[`QD_EV_DOUBLE])
    else $error("double-ready event missing");

endmodule : qdec_core

/* File: logic/qdec_params.svh */
// offsets, field positions, reset values and timing counts of the quadrature decoder
// assumes a 100 MHz system clock and a 12-bit byte address on the register bus
`ifndef QDEC_PARAMS_SVH
`define QDEC_PARAMS_SVH

// register byte offsets
`define QD_OFS_TASKS 12'h000
`define QD_OFS_IRQ_STATUS 12'h300
`define QD_OFS_IRQ_MASK 12'h304
`define QD_OFS_ENABLE 12'h500
`define QD_OFS_LIGHT_POL 12'h504
`define QD_OFS_SAMPLE_INT 12'h508
`define QD_OFS_LAST_VALUE 12'h50C
`define QD_OFS_REPORT_INT 12'h510
`define QD_OFS_TOTAL 12'h514
`define QD_OFS_SNAPSHOT 12'h518

// task register bits, each a write-one trigger
`define QD_TASK_START 0
`define QD_TASK_STOP 1
`define QD_TASK_SNAP_CLR 2
`define QD_TASK_READOUT_CLR 3

// event bits of status and mask registers
`define QD_EV_SAMPLE 0
`define QD_EV_REPORT 1
`define QD_EV_OVERFLOW 2
`define QD_EV_DOUBLE 3

// reset values
`define QD_RST_WORD 32'h00000000
`define QD_RST_CODE 4'h0
`define QD_RST_EVENTS 4'h0

// timing: one microsecond tick from the system clock
`define QD_CLK_PERIOD_NS 10
`define QD_TICK_NS 1000
`define QD_TICK_CYCLES (`QD_TICK_NS / `QD_CLK_PERIOD_NS)
`define QD_SAMPLE_BASE_US 128
`define QD_SAMPLE_CODE_MAX 4'hA
`define QD_REPORT_CODE_ONE 4'h8

// step codes from the phase decoder and the double count limit
`define QD_STEP_DOUBLE 2'h2
`define QD_DOUBLE_MAX 4'hF

`endif

/* File: logic/qdec_pkg.sv */
// types shared by the quadrature decoder files
// constants live in qdec_params.svh
package qdec_pkg;
  typedef enum logic {RUN_IDLE, RUN_ACTIVE} run_state_e;
  typedef logic [1:0] step_t;
  typedef logic [31:0] word_t;
endpackage : qdec_pkg

/* File: logic/qdec_step_decode.sv */
// phase pair decoder: turns two quadrature phases into a signed step per sample
// assumes phase inputs synchronous to the clock and a one-cycle sample strobe
`timescale 1ns/1ps
`include "qdec_params.svh"

module qdec_step_decode
  import qdec_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_restart,
  input wire logic i_sample,
  input wire logic i_phase_a,
  input wire logic i_phase_b,
  output step_t o_step,
  output logic o_valid
);

  logic [1:0] prev_pos;
  logic [1:0] next_prev_pos;
  step_t next_step;
  logic next_valid;
  logic [1:0] cur_pos;

  ////////////////////////////////////////////////////////////////////////////
  // gray position 00,01,11,10 -> 0..3; step is the position difference mod 4,
  // so +1 = 01, -1 = 11 and two positions (both phases moved) = 10
  assign cur_pos = {i_phase_a, i_phase_a ^ i_phase_b};

  always_comb begin
    next_prev_pos = prev_pos;
    next_step = o_step;
    next_valid = 1'b0;
    if (i_restart) begin
      next_prev_pos = cur_pos; // seed so the first sample is not a jump
    end else if (i_sample) begin
      next_step = step_t'(cur_pos - prev_pos);
      next_valid = 1'b1;
      next_prev_pos = cur_pos;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_pos <= 2'h0;
      o_step <= 2'h0;
      o_valid <= 1'b0;
    end else begin
      prev_pos <= next_prev_pos;
      o_step <= next_step;
      o_valid <= next_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  step_forward_a: assert property (
    (i_sample && !i_restart && prev_pos == 2'h0 && cur_pos == 2'h1)
      |=> (o_valid && o_step == 2'h1))
    else $error("forward step not reported as plus one");

  step_double_a: assert property (
    (i_sample && !i_restart && (cur_pos ^ prev_pos) == 2'h2)
      |=> (o_valid && o_step == `QD_STEP_DOUBLE))
    else $error("double transition not reported as two");

endmodule : qdec_step_decode

/* File: tb/qdec_encoder_model.sv */
// behavioural quadrature encoder facing the decoder phase pins
// assumes move commands arrive one clock wide, synchronous to i_clk_sys
`timescale 1ns/1ps

module qdec_encoder_model (
  input wire logic i_clk_sys,
  input wire logic [1:0] i_move,
  output logic o_phase_a,
  output logic o_phase_b
);
  ////////////////////////////////////////////////////////////////////////////
  // shaft position, two bits of it are enough for the gray phases
  logic [1:0] pos = 2'h0;

  // 1 forward, 2 backward, 3 jumps two steps so both phases flip at once
  always @(posedge i_clk_sys) begin
    case (i_move)
      2'h1: pos <= pos + 2'h1;
      2'h2: pos <= pos - 2'h1;
      2'h3: pos <= pos + 2'h2;
      default: pos <= pos;
    endcase
  end

  // gray coding: 00, 01, 11, 10 going forward
  assign o_phase_a = pos[1];
  assign o_phase_b = pos[1] ^ pos[0];
endmodule : qdec_encoder_model

/* File: tb/tb_quadrature_decoder_core.sv */
// self-checking bench of the quadrature decoder core, APB master and encoder model
// assumes the sample base shortened to 1 us, so one sample takes 100 clocks
`timescale 1ns/1ps
`include "qdec_params.svh"

module tb_quadrature_decoder_core;
  import qdec_pkg::*;
  typedef struct packed {logic wr; logic [11:0] a; word_t d; word_t x; logic e;} row_s;
  localparam int BASE_US = 1;
  logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [1:0] move = 2'h0;
  word_t prdata, rd;
  logic pready, pslverr, phase_a, phase_b, led, led_oe, pins_active, irq, er;
  int bad_count = 0, tests_run = 0, n;
  row_s rows [16];

  // compares with case equality so an unknown never passes
  `define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin bad_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end

  always #5 clk_sys = ~clk_sys;

  qdec_core #(.P_SAMPLE_BASE_US(BASE_US)) u_dut (.i_clk_sys(clk_sys), .i_reset_n(reset_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_phase_a(phase_a), .i_phase_b(phase_b), .o_led(led), .o_led_oe(led_oe),
    .o_pins_active(pins_active), .o_irq(irq));
  qdec_encoder_model u_enc (.i_clk_sys(clk_sys), .i_move(move), .o_phase_a(phase_a),
    .o_phase_b(phase_b));

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // one APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input word_t d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk_sys); k++; end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin bad_count++; stop_test(); end
  endtask : apb

  task automatic rchk(input logic [11:0] a, input word_t x);
    apb(1'b0, a, 32'h00000000);
    `CHK("read data", x, rd)
  endtask : rchk

  // one encoder move, then a full sample interval so it lands in its own window
  task automatic step(input logic [1:0] m);
    @(posedge clk_sys); move <= m;
    @(posedge clk_sys); move <= 2'h0;
    repeat (104) @(posedge clk_sys);
  endtask : step

  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  // cycles until the interrupt line rises, bounded
  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin @(posedge clk_sys); n++; end
    if (irq !== 1'b1) begin bad_count++; stop_test(); end
  endtask : wait_irq

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{ '{0, `QD_OFS_ENABLE, 0, 0, 0}, '{0, `QD_OFS_LIGHT_POL, 0, 0, 0},
      '{0, `QD_OFS_SAMPLE_INT, 0, 0, 0}, '{0, `QD_OFS_LAST_VALUE, 0, 0, 0},
      '{0, `QD_OFS_REPORT_INT, 0, 0, 0}, '{0, `QD_OFS_TOTAL, 0, 0, 0},
      '{0, `QD_OFS_SNAPSHOT, 0, 0, 0}, '{1, `QD_OFS_LIGHT_POL, 1, 0, 0},
      '{0, `QD_OFS_LIGHT_POL, 0, 1, 0}, '{1, `QD_OFS_SAMPLE_INT, 32'hA, 0, 0},
      '{0, `QD_OFS_SAMPLE_INT, 0, 32'hA, 0}, '{1, `QD_OFS_REPORT_INT, 8, 0, 0},
      '{0, `QD_OFS_REPORT_INT, 0, 8, 0}, '{1, `QD_OFS_TOTAL, 5, 0, 0},
      '{0, `QD_OFS_TOTAL, 0, 0, 0}, '{0, 12'h004, 0, 0, 1} };
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    settle();
    `CHK("pins active after reset", 1'b0, pins_active)
    `CHK("led enable after reset", 1'b0, led_oe)
    // register reset values, access kinds and the unmapped address
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      `CHK("slave error", rows[i].e, er)
      if (!rows[i].e) `CHK("row data", rows[i].x, rd)
    end
    // run with one sample per report, every event unmasked
    apb(1, `QD_OFS_LIGHT_POL, 0); apb(1, `QD_OFS_SAMPLE_INT, 0);
    apb(1, `QD_OFS_IRQ_MASK, 32'hF); apb(1, `QD_OFS_ENABLE, 1);
    settle();
    `CHK("pins active", 1'b1, pins_active)
    `CHK("led enable", 1'b1, led_oe)
    `CHK("led lit low", 1'b0, led)
    repeat (3) step(2'h1);
    rchk(`QD_OFS_LAST_VALUE, 32'h00000001);
    rchk(`QD_OFS_TOTAL, 32'h00000003);
    step(2'h2);
    rchk(`QD_OFS_LAST_VALUE, 32'hFFFFFFFF);
    rchk(`QD_OFS_TOTAL, 32'h00000002);
    step(2'h3);
    rchk(`QD_OFS_LAST_VALUE, 32'h00000002);
    rchk(`QD_OFS_TOTAL, 32'h00000002);
    rchk(`QD_OFS_IRQ_STATUS, 32'h0000000B);
    `CHK("irq raised", 1'b1, irq)
    apb(1, `QD_OFS_LIGHT_POL, 1);
    settle();
    `CHK("led lit high", 1'b1, led)
    // both clear tasks: snapshot first, then the total drops to zero
    apb(1, `QD_OFS_TASKS, 32'h4);
    rchk(`QD_OFS_SNAPSHOT, 32'h00000002);
    rchk(`QD_OFS_TOTAL, 32'h00000000);
    step(2'h1);
    apb(1, `QD_OFS_TASKS, 32'h8);
    rchk(`QD_OFS_SNAPSHOT, 32'h00000001);
    rchk(`QD_OFS_TOTAL, 32'h00000000);
    apb(1, `QD_OFS_IRQ_MASK, 0);
    settle();
    `CHK("irq masked", 1'b0, irq)
    apb(1, `QD_OFS_ENABLE, 0);
    settle();
    `CHK("pins released", 1'b0, pins_active)
    `CHK("led released", 1'b0, led_oe)
    apb(1, `QD_OFS_IRQ_STATUS, 32'hF);
    rchk(`QD_OFS_IRQ_STATUS, 32'h00000000);
    // code 2 gives a four-fold interval, timed from the enable write
    apb(1, `QD_OFS_SAMPLE_INT, 2); apb(1, `QD_OFS_IRQ_MASK, 1); apb(1, `QD_OFS_ENABLE, 1);
    wait_irq();
    `CHK("interval ok", 1'b1, n >= 400 * BASE_US && n <= 400 * BASE_US + 6)
    // report code 0 waits ten samples, report time is their product
    apb(1, `QD_OFS_ENABLE, 0); apb(1, `QD_OFS_SAMPLE_INT, 0);
    apb(1, `QD_OFS_REPORT_INT, 0); apb(1, `QD_OFS_IRQ_STATUS, 32'hF);
    apb(1, `QD_OFS_IRQ_MASK, 2); apb(1, `QD_OFS_ENABLE, 1);
    step(2'h1);
    wait_irq();
    `CHK("report ok", 1'b1, n + 106 >= 995 && n + 106 <= 1010)
    // stop drives the LED unlit while still enabled, start lights it again
    apb(1, `QD_OFS_TASKS, 32'h2);
    settle();
    `CHK("led unlit when stopped", 1'b0, led)
    apb(1, `QD_OFS_TASKS, 32'h1);
    settle();
    `CHK("led lit after start", 1'b1, led)
    stop_test();
  end
endmodule : tb_quadrature_decoder_core
